// ===== inc/trim_pkg.sv
package trim_pkg;

    // ==================================================
    // Bus layout
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] TRIM_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] SECONDS_OFS = 12'h008;

    // ==================================================
    // Trim register fields
    localparam int PERIOD_SEL_BIT = 7;
    localparam int TRIM_MSB = 6;
    localparam logic [7:0] TRIM_RESET = 8'h00;

    // ==================================================
    // Status register fields
    localparam int STAT_ACTIVE_LSB = 0;
    localparam int STAT_SEC_LSB = 8;
    localparam int STAT_MODE_LSB = 16;
    localparam int STAT_PENDING_BIT = 18;

    // ==================================================
    // Timekeeping
    localparam int OSC_COUNTS_PER_SEC = 32768;
    localparam logic [5:0] PERIOD_SHORT_S = 6'h14;
    localparam logic [5:0] PERIOD_LONG_S = 6'h3C;
    localparam int UNIT_SHIFT = 1;
    localparam logic [7:0] LOSS_BASE = 8'h80;
    localparam logic [6:0] LOSS_NOP_A = 7'h40;
    localparam logic [6:0] LOSS_NOP_B = 7'h41;
    localparam logic [6:0] GAIN_BASE = 7'h01;

    typedef enum logic [1:0] {
        ADJ_NONE = 2'b00,
        ADJ_REMOVE = 2'b01,
        ADJ_ADD = 2'b10
    } adj_mode_t;

endpackage : trim_pkg

// ===== inc/osc_if.sv
`timescale 1ns/1ps

interface osc_if;
    logic tick;
    logic level;

    modport source
    (
        output tick,
        output level
    );

    modport sink
    (
        input tick,
        input level
    );
endinterface : osc_if

// ===== design/osc_sampler.sv
`timescale 1ns/1ps

module osc_sampler
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic crystal_in,
    osc_if.source osc
);
    import trim_pkg::*;

    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic tick_q;
    logic level_q;

    // ==================================================
    // Two-stage synchroniser for the crystal pin
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= crystal_in;
            sync2_q <= sync1_q;
        end
    end

    // ==================================================
    // Rising edge marks one oscillator count
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            prev_q <= 1'b0;
            tick_q <= 1'b0;
            level_q <= 1'b0;
        end
        else
        begin
            prev_q <= sync2_q;
            tick_q <= sync2_q & ~prev_q;
            level_q <= sync2_q;
        end
    end

    assign osc.tick = tick_q;
    assign osc.level = level_q;

endmodule : osc_sampler

// ===== design/timekeeping_trim_logic.sv
`timescale 1ns/1ps

// Operation
// - Period select 0 corrects every 20 seconds
// - Period select 1 corrects every 60 seconds
// - Trim bits 6..1 zero disable correction
// - Trim is 7-bit signed code, bits 0-6
// - 20 s unit equals about 3.051 ppm
// - 60 s unit equals about 1.017 ppm
// - Sub-clock output follows crystal continuously
// - Loss codes are 128 minus magnitude
// - Trim never alters sub-clock output frequency
module timekeeping_trim_logic
#(
    parameter int SEC_COUNTS = trim_pkg::OSC_COUNTS_PER_SEC
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [trim_pkg::ADDR_W-1:0] paddr,
    input wire logic [trim_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [trim_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic crystal_in,
    output logic crystal_out,
    output logic sub_clock_out,
    output logic second_tick
);
    import trim_pkg::*;

    localparam logic [17:0] BASE_LEN = 18'(SEC_COUNTS);

    // ==================================================
    // Helper functions
    function automatic adj_mode_t adjust_mode(input logic [6:0] code);
        adj_mode_t m;
        m = ADJ_NONE;
        if (code[TRIM_MSB:1] == 6'h00)
        begin
            m = ADJ_NONE;
        end
        else if (!code[TRIM_MSB])
        begin
            m = ADJ_ADD;
        end
        else if (code == LOSS_NOP_A || code == LOSS_NOP_B)
        begin
            m = ADJ_NONE;
        end
        else
        begin
            m = ADJ_REMOVE;
        end
        return m;
    endfunction : adjust_mode

    // Two counts per unit; a fast crystal (gain) lengthens the second
    function automatic logic [7:0] adjust_amount(input logic [6:0] code);
        logic [7:0] mag;
        mag = 8'h00;
        case (adjust_mode(code))
            ADJ_ADD:
            begin
                mag = {1'b0, code - GAIN_BASE};
            end
            ADJ_REMOVE:
            begin
                mag = LOSS_BASE - {1'b0, code};
            end
            default:
            begin
                mag = 8'h00;
            end
        endcase
        return 8'(mag << UNIT_SHIFT);
    endfunction : adjust_amount

    function automatic logic [17:0] second_length(input logic [6:0] code);
        logic [17:0] len;
        len = BASE_LEN;
        case (adjust_mode(code))
            ADJ_REMOVE:
            begin
                len = BASE_LEN - {10'h000, adjust_amount(code)};
            end
            ADJ_ADD:
            begin
                len = BASE_LEN + {10'h000, adjust_amount(code)};
            end
            default:
            begin
                len = BASE_LEN;
            end
        endcase
        return len;
    endfunction : second_length

    function automatic logic [5:0] period_length(input logic sel);
        return sel ? PERIOD_LONG_S : PERIOD_SHORT_S;
    endfunction : period_length

    function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction : is_addr

    // ==================================================
    // Oscillator sampling
    osc_if osc ();

    osc_sampler u_osc
    (
        .clk(clk),
        .rst_n(rst_n),
        .crystal_in(crystal_in),
        .osc(osc)
    );

    // ==================================================
    // Declarations
    logic [7:0] trim_q;
    logic [7:0] active_q;
    logic pending_q;
    logic [17:0] sub_cnt_q;
    logic [5:0] sec_q;
    logic [31:0] seconds_q;
    logic tick_q;
    logic clk_out_q;
    logic xtal_out_q;
    logic [DATA_W-1:0] rdata_q;
    logic setup;
    logic access;
    logic wr_trim;
    logic mapped;
    logic last_sec;
    logic [17:0] cur_len;
    logic sec_end;
    logic period_end;

    // ==================================================
    // APB decode
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign mapped = is_addr(paddr, TRIM_OFS) | is_addr(paddr, STATUS_OFS)
                    | is_addr(paddr, SECONDS_OFS);
    assign wr_trim = access & pwrite & pstrb[0] & is_addr(paddr, TRIM_OFS);
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = rdata_q;

    // Read data captured in the setup cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (setup && !pwrite)
        begin
            rdata_q <= 32'h0000_0000;
            if (is_addr(paddr, TRIM_OFS))
            begin
                rdata_q[7:0] <= trim_q;
            end
            else if (is_addr(paddr, STATUS_OFS))
            begin
                rdata_q[STAT_ACTIVE_LSB +: 8] <= active_q;
                rdata_q[STAT_SEC_LSB +: 6] <= sec_q;
                rdata_q[STAT_MODE_LSB +: 2] <= adjust_mode(active_q[TRIM_MSB:0]);
                rdata_q[STAT_PENDING_BIT] <= pending_q;
            end
            else if (is_addr(paddr, SECONDS_OFS))
            begin
                rdata_q <= seconds_q;
            end
        end
    end

    // ==================================================
    // Trim register, software side
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            trim_q <= TRIM_RESET;
        end
        else if (wr_trim)
        begin
            trim_q <= pwdata[7:0];
        end
    end

    // ==================================================
    // Second and period boundaries
    assign last_sec = sec_q == period_length(active_q[PERIOD_SEL_BIT]) - 6'h01;
    assign cur_len = last_sec ? second_length(active_q[TRIM_MSB:0]) : BASE_LEN;
    assign sec_end = osc.tick & (sub_cnt_q == cur_len - 18'h0_0001);
    assign period_end = sec_end & last_sec;

    // Oscillator counts within the current second
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sub_cnt_q <= 18'h0_0000;
        end
        else if (sec_end)
        begin
            sub_cnt_q <= 18'h0_0000;
        end
        else if (osc.tick)
        begin
            sub_cnt_q <= sub_cnt_q + 18'h0_0001;
        end
    end

    // Position inside the correction period
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sec_q <= 6'h00;
        end
        else if (period_end)
        begin
            sec_q <= 6'h00;
        end
        else if (sec_end)
        begin
            sec_q <= sec_q + 6'h01;
        end
    end

    // Elapsed seconds and one-second pulse
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            seconds_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= sec_end;
            if (sec_end)
            begin
                seconds_q <= seconds_q + 32'h0000_0001;
            end
        end
    end

    // ==================================================
    // Trim setting in force, swapped only at a period boundary
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            active_q <= TRIM_RESET;
        end
        else if (period_end)
        begin
            active_q <= trim_q;
        end
    end

    // Pending flag: a write in the boundary cycle stays pending
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pending_q <= 1'b0;
        end
        else if (wr_trim)
        begin
            pending_q <= 1'b1;
        end
        else if (period_end)
        begin
            pending_q <= 1'b0;
        end
    end

    // ==================================================
    // Crystal-side outputs, untouched by the trim path
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            clk_out_q <= 1'b0;
            xtal_out_q <= 1'b1;
        end
        else
        begin
            clk_out_q <= osc.level;
            xtal_out_q <= ~osc.level;
        end
    end

    assign sub_clock_out = clk_out_q;
    assign crystal_out = xtal_out_q;
    assign second_tick = tick_q;

endmodule : timekeeping_trim_logic

// ===== tb/trim_chk.sv
`timescale 1ns/1ps

module trim_chk
import trim_pkg::*;
#(
    parameter int SEC_COUNTS = 256
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [trim_pkg::ADDR_W-1:0] paddr,
    input wire logic [trim_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic crystal_in,
    input wire logic crystal_out,
    input wire logic sub_clock_out,
    input wire logic second_tick
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ==========
    // Oscillator rises within one second
    logic [15:0] rise_q;
    always_ff @(posedge clk)
    begin
        if (!rst_n || second_tick)
            rise_q <= 16'h0000;
        else if ($rose(sub_clock_out))
            rise_q <= rise_q + 16'h0001;
    end

    chk_bus_ready: assert property (psel && penable |-> pready)
        else $error("no ready in access");
    chk_bus_unmapped: assert property (psel && penable && paddr > SECONDS_OFS |-> pslverr)
        else $error("no error on unmapped");
    chk_trim_mapped: assert property (psel && penable && paddr == TRIM_OFS |-> !pslverr)
        else $error("error on trim access");
    chk_trim_upper: assert property (psel && penable && !pwrite && paddr == TRIM_OFS
        |-> prdata[31:8] == 0)
        else $error("trim upper bits set");
    chk_sub_follow: assert property ($rose(crystal_in) |-> ##[3:5] $rose(sub_clock_out))
        else $error("sub clock lost edge");
    chk_xtal_inverse: assert property (crystal_out != sub_clock_out)
        else $error("crystal out not inverse");
    chk_tick_single: assert property (second_tick |=> !second_tick [*8])
        else $error("tick too long");
    chk_second_len: assert property (second_tick |-> rise_q <= SEC_COUNTS + 126)
        else $error("second too long");
endmodule : trim_chk

// ===== tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import trim_pkg::*;
    localparam int SEC = 256;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic crystal_in = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic crystal_out;
    logic sub_clock_out;
    logic second_tick;
    int error_cnt = 0;
    int compares = 0;
    int seed = 87934;
    int cyc = 0;

    timekeeping_trim_logic #(.SEC_COUNTS(SEC)) dut_u (.clk(clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .crystal_in(crystal_in), .crystal_out(crystal_out),
        .sub_clock_out(sub_clock_out), .second_tick(second_tick));

    always #10 clk = ~clk;

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        crystal_in <= ~crystal_in;
    end

    function automatic int adj(input logic [6:0] c);
        if (c[6:1] == 6'h00 || c == 7'h40 || c == 7'h41)
            return 0;
        if (c < 7'h40)
            return 2 * (int'(c) - 1);
        return -2 * (128 - int'(c));
    endfunction : adj

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] rd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    initial
    begin
        logic [31:0] rd;
        logic [7:0] wr [3];
        logic [7:0] inf;
        logic [7:0] pend;
        int last;
        int sec;
        int p;
        int e;
        int n;
        logic [1:0] m;
        wr[0] = 8'h80 | 8'(2 + $unsigned($random(seed)) % 62);
        wr[1] = 8'(66 + $unsigned($random(seed)) % 62);
        wr[2] = 8'h01;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, TRIM_OFS, 32'h0000_0000, 4'hF, rd);
        check(rd, 32'h0000_0000);
        apb(1'b0, 12'h00C, 32'h0000_0000, 4'hF, rd);
        check(rd, 32'h0000_0000);
        do @(negedge clk); while (second_tick !== 1'b1);
        last = cyc;
        sec = 1;
        n = 1;
        p = 0;
        inf = 8'h00;
        pend = 8'h00;
        while (p < 4)
        begin
            do @(negedge clk); while (second_tick !== 1'b1);
            e = SEC;
            if (sec == (inf[7] ? 59 : 19))
                e += adj(inf[6:0]);
            check(32'(cyc - last), 32'(2 * e));
            last = cyc;
            sec++;
            n++;
            if (sec == (inf[7] ? 60 : 20))
            begin
                sec = 0;
                p++;
                inf = pend;
            end
            if (sec == 3 && p < 3)
            begin
                rd = $random(seed);
                apb(1'b1, TRIM_OFS, {rd[31:8], wr[p]}, 4'hF, rd);
                pend = wr[p];
                apb(1'b0, STATUS_OFS, 32'h0000_0000, 4'hF, rd);
                m = adj(inf[6:0]) > 0 ? 2'h2 : (adj(inf[6:0]) < 0 ? 2'h1 : 2'h0);
                check(32'({rd[18:16], rd[13:0]}), 32'({1'b1, m, 6'h03, inf}));
                apb(1'b1, TRIM_OFS, 32'h0000_00FF, 4'hE, rd);
                apb(1'b0, TRIM_OFS, 32'h0000_0000, 4'hF, rd);
                check(rd, {24'h00_0000, pend});
            end
        end
        apb(1'b0, SECONDS_OFS, 32'h0000_0000, 4'hF, rd);
        check(rd, 32'(n));
        conclude();
    end

    initial
    begin
        repeat (80000) @(posedge clk);
        error_cnt++;
        conclude();
    end
endmodule : tb_top

bind timekeeping_trim_logic trim_chk #(.SEC_COUNTS(SEC_COUNTS)) chk_u (.clk(clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crystal_in(crystal_in),
    .crystal_out(crystal_out), .sub_clock_out(sub_clock_out),
    .second_tick(second_tick));
